// ---- src/adc_result_regs.sv ----
// Operation
// - bus current word at 0x25, code scaling depends on switched-cap or bypass mode
// - bus voltage word at 0x27, zero offset, 1.002 mV step
// - first input voltage word at 0x29, 3 mV offset, 1.0008 mV step
// - second input voltage word at 0x2b, 5 mV offset, 1.0006 mV step
// - output voltage word at 0x2d, 2 mV offset, 1.0037 mV step
// - battery voltage word at 0x2f, 1 mV offset, 1.017 mV step
// - battery current word at 0x31, minus 150 mA offset, 0.999 mA step
// - bus thermistor ratio word at 0x33, 0.1 percent offset, 0.09860 step
// - battery thermistor ratio word at 0x35, 0.065 percent offset, 0.09762 step
// - die temperature word at 0x37, minus 3.5 degC offset, 0.5079 step
// - results are read-only, ignore writes, read zero after reset
// - stage runs at 500 kHz by default; host picks frequency at 0x10
`include "adc_result_params.svh"

module adc_result_regs #(
	parameter logic [6:0] TARGET_ADDR = `TARGET_ADDR_DEFAULT,
	parameter logic [`FSW_WIDTH-1:0] FSW_RESET = `FSW_DEFAULT
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// serial control port, open drain data
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// conversion results from the converter
	input wire logic sample_valid,
	input wire logic [3:0] sample_channel,
	input wire logic [15:0] sample_code,
	input wire logic sample_bypass,
	// power stage control
	output logic [`FSW_WIDTH-1:0] fsw_select,
	output logic bus_current_bypass
);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------

	// {hit, low byte, channel} for a byte address inside the result block
	function automatic logic [5:0] decode_result(input logic [7:0] addr);
		logic [7:0] off;
		off = 8'(addr - `BUS_CURRENT_ADDR);
		if ((addr >= `BUS_CURRENT_ADDR) && (addr <= 8'(`DIE_TEMPERATURE_ADDR + 8'h01))) begin
			decode_result = {1'b1, off[0], off[4:1]};
		end else begin
			decode_result = 6'h00;
		end
	endfunction : decode_result

	// ----------------------------------------------------------------
	// pins and storage
	// ----------------------------------------------------------------
	logic [1:0] pins_s;
	logic scl_s;
	logic sda_s;
	result_if rif ();

	// both port pins cross into the clock domain before any decode
	pin_sync #(
		.WIDTH(2),
		.IDLE(2'h3)
	) u_sync (
		.clock(clock),
		.rst(rst),
		.din({scl_in, sda_in}),
		.dout(pins_s)
	);

	result_bank #(
		.NUM_CH(10)
	) u_bank (
		.clock(clock),
		.rst(rst),
		.rif(rif)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// converter samples go straight into the bank
	assign rif.sample_valid = sample_valid;
	assign rif.sample_chan = adc_result_pkg::channel_t'(sample_channel);
	assign rif.sample_code = sample_code;
	assign rif.sample_bypass = sample_bypass;

	// ----------------------------------------------------------------
	// port state
	// ----------------------------------------------------------------
	adc_result_pkg::port_state_t state_r, state_nxt;
	logic scl_q_r, scl_q_nxt;
	logic sda_q_r, sda_q_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	adc_result_pkg::byte_t shift_r, shift_nxt;
	logic rw_r, rw_nxt;
	adc_result_pkg::byte_t ptr_r, ptr_nxt;
	logic drive_r, drive_nxt;
	adc_result_pkg::byte_t hold_r, hold_nxt;
	adc_result_pkg::byte_t hold_ptr_r, hold_ptr_nxt;
	logic hold_v_r, hold_v_nxt;
	logic [`FSW_WIDTH-1:0] fsw_r, fsw_nxt;

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic [5:0] dec;
	adc_result_pkg::byte_t tx_byte;

	// line events; data may only move while the clock line is low
	assign scl_rise = scl_s & ~scl_q_r;
	assign scl_fall = ~scl_s & scl_q_r;
	assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
	assign stop_det = scl_s & scl_q_r & ~sda_q_r & sda_s;

	// the word addressed by the pointer is offered to the read path
	assign dec = decode_result(ptr_r);
	assign rif.rd_chan = adc_result_pkg::channel_t'(dec[3:0]);

	// byte to send for the current pointer
	always_comb begin
		tx_byte = 8'h00;
		if (dec[5]) begin
			if (!dec[4]) begin
				tx_byte = rif.rd_word[15:8];
			end else if (hold_v_r && (hold_ptr_r == ptr_r)) begin
				// low byte latched with its high byte, so a newer sample cannot split the pair
				tx_byte = hold_r;
			end else begin
				tx_byte = rif.rd_word[7:0];
			end
		end else if (ptr_r == `FREQ_REG_ADDR) begin
			tx_byte[`FSW_LSB +: `FSW_WIDTH] = fsw_r;
		end
	end

	// protocol next state
	always_comb begin
		state_nxt = state_r;
		scl_q_nxt = scl_s;
		sda_q_nxt = sda_s;
		cnt_nxt = cnt_r;
		shift_nxt = shift_r;
		rw_nxt = rw_r;
		ptr_nxt = ptr_r;
		drive_nxt = drive_r;
		hold_nxt = hold_r;
		hold_ptr_nxt = hold_ptr_r;
		hold_v_nxt = hold_v_r;
		fsw_nxt = fsw_r;
		if (start_det) begin
			// a repeated start also lands here and keeps the pointer
			state_nxt = adc_result_pkg::st_addr;
			cnt_nxt = 4'h0;
			drive_nxt = 1'b0;
			hold_v_nxt = 1'b0;
		end else if (stop_det) begin
			state_nxt = adc_result_pkg::st_idle;
			drive_nxt = 1'b0;
			hold_v_nxt = 1'b0;
		end else begin
			case (state_r)
				adc_result_pkg::st_addr, adc_result_pkg::st_ptr, adc_result_pkg::st_wdata: begin
					if (scl_rise && (cnt_r < `BYTE_BITS)) begin
						shift_nxt = {shift_r[6:0], sda_s};
						cnt_nxt = 4'(cnt_r + 4'h1);
					end else if (scl_fall && (cnt_r == `BYTE_BITS)) begin
						drive_nxt = 1'b1;
						if (state_r == adc_result_pkg::st_addr) begin
							if (shift_r[7:1] == TARGET_ADDR) begin
								rw_nxt = shift_r[0];
								state_nxt = adc_result_pkg::st_addr_ack;
							end else begin
								drive_nxt = 1'b0;
								state_nxt = adc_result_pkg::st_ignore;
							end
						end else if (state_r == adc_result_pkg::st_ptr) begin
							ptr_nxt = shift_r;
							state_nxt = adc_result_pkg::st_ptr_ack;
						end else begin
							// only the frequency field is writable; results drop writes
							if (ptr_r == `FREQ_REG_ADDR) begin
								fsw_nxt = shift_r[`FSW_LSB +: `FSW_WIDTH];
							end
							ptr_nxt = 8'(ptr_r + 8'h01);
							state_nxt = adc_result_pkg::st_wdata_ack;
						end
					end
				end
				adc_result_pkg::st_addr_ack: begin
					if (rw_r && scl_rise) begin
						// hand over in the acknowledge high phase so the first byte loads on its fall
						cnt_nxt = 4'h0;
						state_nxt = adc_result_pkg::st_rdata_ack;
					end else if (!rw_r && scl_fall) begin
						cnt_nxt = 4'h0;
						drive_nxt = 1'b0;
						state_nxt = adc_result_pkg::st_ptr;
					end
				end
				adc_result_pkg::st_ptr_ack, adc_result_pkg::st_wdata_ack: begin
					if (scl_fall) begin
						drive_nxt = 1'b0;
						cnt_nxt = 4'h0;
						state_nxt = adc_result_pkg::st_wdata;
					end
				end
				adc_result_pkg::st_rdata: begin
					if (scl_rise) begin
						cnt_nxt = 4'(cnt_r + 4'h1);
					end else if (scl_fall) begin
						if (cnt_r == `BYTE_BITS) begin
							// release the line for the host acknowledge
							drive_nxt = 1'b0;
							cnt_nxt = 4'h1;
							state_nxt = adc_result_pkg::st_rdata_ack;
						end else begin
							shift_nxt = {shift_r[6:0], 1'b0};
							drive_nxt = ~shift_r[6];
						end
					end
				end
				adc_result_pkg::st_rdata_ack: begin
					// cnt 0 means load on this fall, 1 means acknowledge still due
					if (scl_rise && (cnt_r != 4'h0)) begin
						if (sda_s) begin
							state_nxt = adc_result_pkg::st_ignore;
						end else begin
							cnt_nxt = 4'h0;
						end
					end else if (scl_fall && (cnt_r == 4'h0)) begin
						shift_nxt = tx_byte;
						drive_nxt = ~tx_byte[7];
						ptr_nxt = 8'(ptr_r + 8'h01);
						if (dec[5] && !dec[4]) begin
							hold_nxt = rif.rd_word[7:0];
							hold_ptr_nxt = 8'(ptr_r + 8'h01);
							hold_v_nxt = 1'b1;
						end else begin
							hold_v_nxt = 1'b0;
						end
						state_nxt = adc_result_pkg::st_rdata;
					end
				end
				adc_result_pkg::st_idle, adc_result_pkg::st_ignore: begin
					drive_nxt = 1'b0;
				end
				default: begin
					drive_nxt = 1'b0;
					state_nxt = adc_result_pkg::st_idle;
				end
			endcase
		end
	end

	// protocol registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r <= adc_result_pkg::st_idle;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			cnt_r <= 4'h0;
			shift_r <= 8'h00;
			rw_r <= 1'b0;
			ptr_r <= 8'h00;
			drive_r <= 1'b0;
			hold_r <= 8'h00;
			hold_ptr_r <= 8'h00;
			hold_v_r <= 1'b0;
			fsw_r <= FSW_RESET;
		end else begin
			state_r <= state_nxt;
			scl_q_r <= scl_q_nxt;
			sda_q_r <= sda_q_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			rw_r <= rw_nxt;
			ptr_r <= ptr_nxt;
			drive_r <= drive_nxt;
			hold_r <= hold_nxt;
			hold_ptr_r <= hold_ptr_nxt;
			hold_v_r <= hold_v_nxt;
			fsw_r <= fsw_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------

	// open drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe = drive_r;
	assign fsw_select = fsw_r;
	assign bus_current_bypass = rif.bus_bypass;

endmodule : adc_result_regs

// ---- shared/adc_result_params.svh ----
`ifndef ADC_RESULT_PARAMS_SVH
`define ADC_RESULT_PARAMS_SVH

// ----------------------------------------------------------------
// result register byte offsets (high byte at offset, low byte at +1)
// ----------------------------------------------------------------
`define BUS_CURRENT_ADDR 8'h25
`define BUS_VOLTAGE_ADDR 8'h27
`define INPUT_ONE_VOLTAGE_ADDR 8'h29
`define INPUT_TWO_VOLTAGE_ADDR 8'h2b
`define OUTPUT_VOLTAGE_ADDR 8'h2d
`define BATTERY_VOLTAGE_ADDR 8'h2f
`define BATTERY_CURRENT_ADDR 8'h31
`define BUS_THERMISTOR_ADDR 8'h33
`define BATTERY_THERMISTOR_ADDR 8'h35
`define DIE_TEMPERATURE_ADDR 8'h37
`define RESULT_RESET 16'h0000

// ----------------------------------------------------------------
// host scaling of each code: value = offset + code * step
// offsets and steps in millionths of the unit (mA, mV, %, degC)
// ----------------------------------------------------------------
`define BUS_CURRENT_SC_OFFSET 66000000
`define BUS_CURRENT_SC_STEP 997200
`define BUS_CURRENT_BYP_OFFSET 64000000
`define BUS_CURRENT_BYP_STEP 1027900
`define BUS_VOLTAGE_OFFSET 0
`define BUS_VOLTAGE_STEP 1002000
`define INPUT_ONE_OFFSET 3000000
`define INPUT_ONE_STEP 1000800
`define INPUT_TWO_OFFSET 5000000
`define INPUT_TWO_STEP 1000600
`define OUTPUT_VOLTAGE_OFFSET 2000000
`define OUTPUT_VOLTAGE_STEP 1003700
`define BATTERY_VOLTAGE_OFFSET 1000000
`define BATTERY_VOLTAGE_STEP 1017000
`define BATTERY_CURRENT_OFFSET -150000000
`define BATTERY_CURRENT_STEP 999000
`define BUS_THERMISTOR_OFFSET 100000
`define BUS_THERMISTOR_STEP 98600
`define BATTERY_THERMISTOR_OFFSET 65000
`define BATTERY_THERMISTOR_STEP 97620
`define DIE_TEMPERATURE_OFFSET -3500000
`define DIE_TEMPERATURE_STEP 507900

// ----------------------------------------------------------------
// switching frequency select
// ----------------------------------------------------------------
`define FREQ_REG_ADDR 8'h10
`define FSW_LSB 5
`define FSW_WIDTH 3
`define FSW_DEFAULT 3'h0
`define FSW_DEFAULT_KHZ 500
`define FSW_ADVISED_WITH_BAT_CURRENT_KHZ 375

// ----------------------------------------------------------------
// serial port framing
// ----------------------------------------------------------------
`define BYTE_BITS 4'h8
`define TARGET_ADDR_DEFAULT 7'h2a

`endif

// ---- shared/adc_result_pkg.sv ----
package adc_result_pkg;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef logic [15:0] result_t;
	typedef logic [7:0] byte_t;

	// channel order matches the register order in the map
	typedef enum logic [3:0] {
		bus_current_reading,
		bus_voltage_reading,
		input_one_voltage_reading,
		input_two_voltage_reading,
		output_voltage_reading,
		battery_voltage_reading,
		battery_current_reading,
		bus_thermistor_reading,
		battery_thermistor_reading,
		die_temperature_reading
	} channel_t;

	typedef enum logic [3:0] {
		st_idle,
		st_addr,
		st_addr_ack,
		st_ptr,
		st_ptr_ack,
		st_wdata,
		st_wdata_ack,
		st_rdata,
		st_rdata_ack,
		st_ignore
	} port_state_t;

endpackage : adc_result_pkg

// ---- shared/result_if.sv ----
interface result_if;
	// conversion results into the bank
	logic sample_valid;
	adc_result_pkg::channel_t sample_chan;
	adc_result_pkg::result_t sample_code;
	logic sample_bypass;
	// read side
	adc_result_pkg::channel_t rd_chan;
	adc_result_pkg::result_t rd_word;
	logic bus_bypass;

	modport regs (
		output sample_valid, sample_chan, sample_code, sample_bypass, rd_chan,
		input rd_word, bus_bypass
	);
	modport bank (
		input sample_valid, sample_chan, sample_code, sample_bypass, rd_chan,
		output rd_word, bus_bypass
	);
endinterface : result_if

// ---- src/pin_sync.sv ----
module pin_sync #(
	parameter int WIDTH = 2,
	parameter logic [WIDTH-1:0] IDLE = '1
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// asynchronous levels in, synchronised levels out
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// two stages; meta_r feeds sync_r only
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_r <= IDLE;
			sync_r <= IDLE;
		end else begin
			meta_r <= din;
			sync_r <= meta_r;
		end
	end

	assign dout = sync_r;

endmodule : pin_sync

// ---- src/result_bank.sv ----
`include "adc_result_params.svh"

module result_bank #(
	parameter int NUM_CH = 10
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// results in and read port
	result_if.bank rif
);

	adc_result_pkg::result_t result_r [NUM_CH];
	adc_result_pkg::result_t result_nxt [NUM_CH];
	logic bypass_r;
	logic bypass_nxt;

	// a sample replaces the whole word in one edge, so both bytes stay paired
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			result_nxt[i] = result_r[i];
		end
		bypass_nxt = bypass_r;
		if (rif.sample_valid && (int'(rif.sample_chan) < NUM_CH)) begin
			result_nxt[rif.sample_chan] = rif.sample_code;
			// scaling of the bus current follows the stage mode of its sample
			if (rif.sample_chan == adc_result_pkg::bus_current_reading) begin
				bypass_nxt = rif.sample_bypass;
			end
		end
	end

	// results clear to zero and change only by conversion
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				result_r[i] <= `RESULT_RESET;
			end
			bypass_r <= 1'b0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				result_r[i] <= result_nxt[i];
			end
			bypass_r <= bypass_nxt;
		end
	end

	// unknown channel reads as zero
	assign rif.rd_word = (int'(rif.rd_chan) < NUM_CH) ? result_r[rif.rd_chan] : `RESULT_RESET;
	assign rif.bus_bypass = bypass_r;

endmodule : result_bank

// ---- test/adc_result_regs_assertions.sv ----
`include "adc_result_params.svh"

module adc_result_regs_checker #(
	parameter logic [`FSW_WIDTH-1:0] FSW_RESET = `FSW_DEFAULT
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// serial pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// conversion results
	input wire logic sample_valid,
	input wire logic [3:0] sample_channel,
	input wire logic [15:0] sample_code,
	input wire logic sample_bypass,
	// power stage control
	input wire logic [`FSW_WIDTH-1:0] fsw_select,
	input wire logic bus_current_bypass
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// ----------------------------------------------------------------
	// pin quiet counter
	// ----------------------------------------------------------------
	logic [3:0] quiet_r, quiet_nxt;
	logic scl_prev_r, sda_prev_r;

	// saturating count of cycles with both pins still; the port reacts a
	// few cycles after a pin edge, so a long quiet spell must leave it idle
	always_comb begin
		quiet_nxt = quiet_r;
		if (scl_in != scl_prev_r || sda_in != sda_prev_r) begin
			quiet_nxt = 4'h0;
		end else if (quiet_r != 4'hf) begin
			quiet_nxt = quiet_r + 4'h1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			quiet_r <= 4'h0;
			scl_prev_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end else begin
			quiet_r <= quiet_nxt;
			scl_prev_r <= scl_in;
			sda_prev_r <= sda_in;
		end
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	sequence s_bus_sample;
		sample_valid && sample_channel == 4'h0;
	endsequence
	sequence s_pins_quiet;
		quiet_r >= 4'ha;
	endsequence

	property p_bypass_capture;
		s_bus_sample |=> bus_current_bypass == $past(sample_bypass);
	endproperty
	a_bypass_capture: assert property (p_bypass_capture)
		else $error("bus current mode not taken from its sample");

	property p_bypass_hold;
		!(sample_valid && sample_channel == 4'h0) |=> $stable(bus_current_bypass);
	endproperty
	a_bypass_hold: assert property (p_bypass_hold)
		else $error("bus current mode moved without a bus current sample");

	property p_release_state;
		$fell(rst) |-> fsw_select == FSW_RESET && !bus_current_bypass && !sda_oe;
	endproperty
	a_release_state: assert property (p_release_state)
		else $error("outputs not at reset values after release");

	property p_fsw_quiet;
		s_pins_quiet |-> $stable(fsw_select);
	endproperty
	a_fsw_quiet: assert property (p_fsw_quiet)
		else $error("frequency select moved with the port idle");

	property p_oe_quiet;
		s_pins_quiet |-> $stable(sda_oe);
	endproperty
	a_oe_quiet: assert property (p_oe_quiet)
		else $error("data drive moved with the port idle");

	property p_oe_scl_low;
		$changed(sda_oe) |-> !scl_in;
	endproperty
	a_oe_scl_low: assert property (p_oe_scl_low)
		else $error("data drive changed while serial clock high");

	property p_oe_sync_delay;
		$fell(scl_in) |=> $stable(sda_oe);
	endproperty
	a_oe_sync_delay: assert property (p_oe_sync_delay)
		else $error("data drive reacted before clock synchroniser");

	property p_sda_out_low;
		sda_out == 1'b0;
	endproperty
	a_sda_out_low: assert property (p_sda_out_low)
		else $error("open drain data output not low");
endmodule : adc_result_regs_checker

bind adc_result_regs adc_result_regs_checker #(.FSW_RESET(FSW_RESET)) i_checker (
	.clock(clock), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .sample_valid(sample_valid), .sample_channel(sample_channel),
	.sample_code(sample_code), .sample_bypass(sample_bypass),
	.fsw_select(fsw_select), .bus_current_bypass(bus_current_bypass)
);

// ---- test/monitor_adc_result_regs_bench.sv ----
`include "adc_result_params.svh"

module monitor_adc_result_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int H = 5;
	localparam logic [6:0] TGT = 7'h2a;
	// about 45k cycles of traffic expected; double that is a hang
	localparam int LIMIT = 90000;

	logic clock = 1'b0;
	logic rst = 1'b1;
	logic scl = 1'b1;
	logic host_sda = 1'b1;
	logic sample_valid = 1'b0;
	logic [3:0] sample_channel = 4'h0;
	logic [15:0] sample_code = 16'h0000;
	logic sample_bypass = 1'b0;
	logic sda_out, sda_oe, bus_current_bypass, a;
	logic [`FSW_WIDTH-1:0] fsw_select;
	wire logic sda_pin;
	int err_count = 0;
	int n_compared = 0;
	int cycles = 0;
	adc_result_pkg::result_t v;
	adc_result_pkg::byte_t r;
	adc_result_pkg::result_t codes [10];

	// data line with pull-up: low while either side pulls
	assign sda_pin = host_sda & ~sda_oe;

	always #2 clock = ~clock;

	adc_result_regs #(.TARGET_ADDR(TGT), .FSW_RESET(3'h0)) i_dut (
		.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda_pin), .sda_out(sda_out),
		.sda_oe(sda_oe), .sample_valid(sample_valid), .sample_channel(sample_channel),
		.sample_code(sample_code), .sample_bypass(sample_bypass),
		.fsw_select(fsw_select), .bus_current_bypass(bus_current_bypass)
	);

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask : tick

	// one bit: data set mid-low, sampled at the end of the high phase
	task automatic xbit(input logic b, output logic q);
		tick(H);
		host_sda = b;
		tick(H);
		scl = 1'b1;
		tick(H);
		q = sda_pin;
		scl = 1'b0;
	endtask : xbit

	task automatic xbyte(input adc_result_pkg::byte_t d, input logic last,
			output adc_result_pkg::byte_t q, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], b);
			q = {q[6:0], b};
		end
		xbit(last, ack);
	endtask : xbyte

	task automatic start();
		host_sda = 1'b1;
		tick(H);
		scl = 1'b1;
		tick(H);
		host_sda = 1'b0;
		tick(H);
		scl = 1'b0;
	endtask : start

	// stop then idle long enough for the port to settle
	task automatic stop();
		host_sda = 1'b0;
		tick(H);
		scl = 1'b1;
		tick(H);
		host_sda = 1'b1;
		tick(4 * H);
	endtask : stop

	task automatic put(input logic [3:0] ch, input logic [15:0] code, input logic byp);
		sample_valid = 1'b1;
		sample_channel = ch;
		sample_code = code;
		sample_bypass = byp;
		tick(1);
		sample_valid = 1'b0;
		tick(1);
	endtask : put

	task automatic hdr(input adc_result_pkg::byte_t p, input logic rd);
		adc_result_pkg::byte_t q;
		logic k;
		start();
		xbyte({TGT, 1'b0}, 1'b1, q, k);
		check(k, 1'b0);
		xbyte(p, 1'b1, q, k);
		check(k, 1'b0);
		if (rd) begin
			start();
			xbyte({TGT, 1'b1}, 1'b1, q, k);
			check(k, 1'b0);
		end
	endtask : hdr

	task automatic wr(input adc_result_pkg::byte_t p, input adc_result_pkg::byte_t d);
		adc_result_pkg::byte_t q;
		logic k;
		hdr(p, 1'b0);
		xbyte(d, 1'b1, q, k);
		check(k, 1'b0);
		stop();
	endtask : wr

	// mid injects a new battery current sample between the two bytes
	task automatic rd(input adc_result_pkg::byte_t p, input int n, input logic mid,
			output adc_result_pkg::result_t w);
		adc_result_pkg::byte_t b;
		logic k;
		w = 16'h0000;
		hdr(p, 1'b1);
		for (int j = 0; j < n; j++) begin
			xbyte(8'hff, j == n - 1, b, k);
			if (mid && j == 0) begin
				put(4'h6, 16'h7e81, 1'b0);
			end
			w = {w[7:0], b};
		end
		stop();
	endtask : rd

	task automatic check_all();
		adc_result_pkg::result_t w;
		for (int i = 0; i < 10; i++) begin
			rd(8'(8'h25 + 2 * i), 2, 1'b0, w);
			check(w, codes[i]);
		end
	endtask : check_all

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	// hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_count++;
			summarize();
		end
	end

	initial begin
		tick(12);
		rst = 1'b0;
		tick(4);
		foreach (codes[i]) codes[i] = 16'h0000;
		check_all();
		check(sda_out, 1'b0);
		check(fsw_select, 3'h0);
		rd(8'h10, 1, 1'b0, v);
		check(v, 16'h0000);
		// distinct code per channel, bus current in bypass mode
		foreach (codes[i]) begin
			codes[i] = {4'(i), 4'ha, 4'(9 - i), 4'h5};
			put(4'(i), codes[i], i == 0);
		end
		check(bus_current_bypass, 1'b1);
		check_all();
		// writes to every result byte are dropped
		for (int j = 0; j < 20; j++) wr(8'(8'h25 + j), 8'h5a);
		check_all();
		put(4'h1, 16'h1234, 1'b0);
		codes[1] = 16'h1234;
		check(bus_current_bypass, 1'b1);
		put(4'h0, codes[0], 1'b0);
		check(bus_current_bypass, 1'b0);
		// frequency field sits in bits 7:5 only
		wr(8'h10, 8'hff);
		check(fsw_select, 3'h7);
		rd(8'h10, 1, 1'b0, v);
		check(v, 16'h00e0);
		wr(8'h10, 8'h7f);
		check(fsw_select, 3'h3);
		// new sample between the bytes must not split the pair
		rd(8'h31, 2, 1'b1, v);
		check(v, codes[6]);
		rd(8'h32, 1, 1'b0, v);
		check(v, 16'h0081);
		codes[6] = 16'h7e81;
		rd(8'h31, 2, 1'b0, v);
		check(v, codes[6]);
		rd(8'h36, 2, 1'b0, v);
		check(v, {codes[8][7:0], codes[9][15:8]});
		// another target address is not answered
		start();
		xbyte({7'h2b, 1'b0}, 1'b1, r, a);
		check(a, 1'b1);
		stop();
		// second reset mid-run
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		tick(4);
		foreach (codes[i]) codes[i] = 16'h0000;
		check_all();
		check(fsw_select, 3'h0);
		summarize();
	end
endmodule : monitor_adc_result_regs_bench
